/* File: src/cbwd_top.sv */
// Purpose: Socket window registers and PCI/CardBus forwarding decode
// Assumes: Single clock, AHB-Lite register access, one address per request
// Notes: Reads take one wait state, writes none
//
// What this block does
// - Memory limit bits 31..12 are writable, placing edges at 4 KB granularity.
// - Memory limit bits 11..0 read zero; writes to them are dropped.
// - Memory window 0 prefetch follows control bit 8, window 1 bit 9.
// - A memory window with base and limit both zero claims nothing.
// - Memory windows decide downstream claims and upstream forwarding.
// - I/O base low half is offset in page; bits 31..16 select the page.
// - I/O base bits 31..2 writable; bits 1..0 read zero.
// - An I/O window with base and limit both zero claims nothing.
// - I/O limit bits 15..2 writable, upper bound within the base page.
// - I/O limit bits 31..16 and 1..0 read zero; writes ignored.
// - I/O upper bound compare treats limit bits 1..0 as ones.
// - I/O windows decide downstream claims and upstream forwarding.
// - Eight-bit interrupt routing register, fully writable, resets to all ones.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cbwd_map.svh"
module cbwd_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Downstream decode request from the PCI side
  input wire logic ds_valid,
  input wire logic [31:0] ds_addr,
  input wire logic ds_is_io,
  // Downstream decode answer
  output logic ds_claim,
  output logic [1:0] ds_window,
  output logic ds_prefetch,
  // Upstream decode request from a card master
  input wire logic us_valid,
  input wire logic [31:0] us_addr,
  input wire logic us_is_io,
  // Upstream decode answer
  output logic us_forward
);

  cbwd_pkg::cbwd_bus_state_e state;
  cbwd_pkg::cbwd_bus_state_e next_state;
  logic [7:0] addr_q;
  logic accept;

  cbwd_pkg::cbwd_word_t mem_base [2];
  cbwd_pkg::cbwd_word_t mem_lim [2];
  cbwd_pkg::cbwd_word_t io_base [2];
  cbwd_pkg::cbwd_word_t io_lim [2];
  logic [7:0] irq_line;
  cbwd_pkg::cbwd_word_t prefetch_ctl;

  cbwd_pkg::cbwd_word_t win_lo [4];
  cbwd_pkg::cbwd_word_t win_hi [4];
  logic [3:0] win_en;
  logic [3:0] ds_hit;
  logic [3:0] us_hit;
  logic [3:0] ds_kind_hit;
  logic [3:0] us_kind_hit;

  logic next_ds_claim;
  logic [1:0] next_ds_window;
  logic next_ds_prefetch;
  cbwd_pkg::cbwd_word_t next_rdata;

  // Bus front end

  assign accept = hsel && htrans[`CBWD_HTRANS_ACT] && hready;
  // A read holds the bus one cycle so that a write just before it is visible
  assign hreadyout = (state != cbwd_pkg::ST_READ);
  assign hresp = 1'b0;

  always_comb begin
    next_state = cbwd_pkg::ST_IDLE;
    case (state)
      cbwd_pkg::ST_READ: next_state = cbwd_pkg::ST_READ_OUT;
      cbwd_pkg::ST_IDLE, cbwd_pkg::ST_WRITE, cbwd_pkg::ST_READ_OUT: begin
        if (accept && hwrite) begin
          next_state = cbwd_pkg::ST_WRITE;
        end else if (accept) begin
          next_state = cbwd_pkg::ST_READ;
        end
      end
      default: next_state = cbwd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= cbwd_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
    end else if (accept) begin
      addr_q <= haddr[`CBWD_ADDR_F];
    end
  end

  // Register writes, committed at the end of the data phase

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_base[0] <= `CBWD_REG_RST;
      mem_base[1] <= `CBWD_REG_RST;
      mem_lim[0] <= `CBWD_REG_RST;
      mem_lim[1] <= `CBWD_REG_RST;
    end else if (state == cbwd_pkg::ST_WRITE) begin
      case (addr_q)
        `CBWD_OFS_MEM0_BASE: mem_base[0] <= hwdata & `CBWD_MEM_WMASK;
        `CBWD_OFS_MEM1_BASE: mem_base[1] <= hwdata & `CBWD_MEM_WMASK;
        `CBWD_OFS_MEM0_LIM: mem_lim[0] <= hwdata & `CBWD_MEM_WMASK;
        `CBWD_OFS_MEM1_LIM: mem_lim[1] <= hwdata & `CBWD_MEM_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_base[0] <= `CBWD_REG_RST;
      io_base[1] <= `CBWD_REG_RST;
      io_lim[0] <= `CBWD_REG_RST;
      io_lim[1] <= `CBWD_REG_RST;
    end else if (state == cbwd_pkg::ST_WRITE) begin
      case (addr_q)
        `CBWD_OFS_IO0_BASE: io_base[0] <= hwdata & `CBWD_IO_BASE_WMASK;
        `CBWD_OFS_IO1_BASE: io_base[1] <= hwdata & `CBWD_IO_BASE_WMASK;
        `CBWD_OFS_IO0_LIM: io_lim[0] <= hwdata & `CBWD_IO_LIM_WMASK;
        `CBWD_OFS_IO1_LIM: io_lim[1] <= hwdata & `CBWD_IO_LIM_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_line <= `CBWD_IRQ_RST;
    end else if (state == cbwd_pkg::ST_WRITE && addr_q == `CBWD_OFS_IRQ_LINE) begin
      irq_line <= hwdata[`CBWD_IRQ_F];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prefetch_ctl <= `CBWD_REG_RST;
    end else if (state == cbwd_pkg::ST_WRITE && addr_q == `CBWD_OFS_PREFETCH) begin
      prefetch_ctl <= hwdata & `CBWD_PF_MASK;
    end
  end

  // Read path; unmapped offsets read zero

  always_comb begin
    next_rdata = `CBWD_WORD_ZERO;
    case (addr_q)
      `CBWD_OFS_MEM0_BASE: next_rdata = mem_base[0];
      `CBWD_OFS_MEM0_LIM: next_rdata = mem_lim[0];
      `CBWD_OFS_MEM1_BASE: next_rdata = mem_base[1];
      `CBWD_OFS_MEM1_LIM: next_rdata = mem_lim[1];
      `CBWD_OFS_IO0_BASE: next_rdata = io_base[0];
      `CBWD_OFS_IO0_LIM: next_rdata = io_lim[0];
      `CBWD_OFS_IO1_BASE: next_rdata = io_base[1];
      `CBWD_OFS_IO1_LIM: next_rdata = io_lim[1];
      `CBWD_OFS_IRQ_LINE: next_rdata = {24'h000000, irq_line};
      `CBWD_OFS_PREFETCH: next_rdata = prefetch_ctl;
      `CBWD_OFS_STATUS: next_rdata = {24'h000000, us_forward, ds_window, ds_claim, win_en};
      default: next_rdata = `CBWD_WORD_ZERO;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `CBWD_WORD_ZERO;
    end else if (state == cbwd_pkg::ST_READ) begin
      hrdata <= next_rdata;
    end
  end

  // Window bounds

  always_comb begin
    win_lo[0] = mem_base[0];
    win_lo[1] = mem_base[1];
    // Limit names the last 4 KB page, so its low bits count as ones
    win_hi[0] = mem_lim[0] | `CBWD_MEM_LOW_ONES;
    win_hi[1] = mem_lim[1] | `CBWD_MEM_LOW_ONES;
    win_lo[2] = io_base[0];
    win_lo[3] = io_base[1];
    // Page of the top comes from the base, last doubleword is included
    win_hi[2] = {io_base[0][`CBWD_IO_PAGE_F], io_lim[0][`CBWD_IO_OFS_F],
                 `CBWD_IO_LOW_ONES};
    win_hi[3] = {io_base[1][`CBWD_IO_PAGE_F], io_lim[1][`CBWD_IO_OFS_F],
                 `CBWD_IO_LOW_ONES};
  end

  assign win_en[0] = (mem_base[0] != `CBWD_REG_RST) || (mem_lim[0] != `CBWD_REG_RST);
  assign win_en[1] = (mem_base[1] != `CBWD_REG_RST) || (mem_lim[1] != `CBWD_REG_RST);
  assign win_en[2] = (io_base[0] != `CBWD_REG_RST) || (io_lim[0] != `CBWD_REG_RST);
  assign win_en[3] = (io_base[1] != `CBWD_REG_RST) || (io_lim[1] != `CBWD_REG_RST);

  for (genvar i = 0; i < 4; i++) begin : g_win
    cbwd_window u_win (
      .hclk(hclk),
      .hresetn(hresetn),
      .win_en(win_en[i]),
      .lo(win_lo[i]),
      .hi(win_hi[i]),
      .addr_a(ds_addr),
      .addr_b(us_addr),
      .hit_a(ds_hit[i]),
      .hit_b(us_hit[i])
    );
  end

  // Only windows of the request's own space count
  assign ds_kind_hit = ds_hit & (ds_is_io ? 4'hC : 4'h3);
  assign us_kind_hit = us_hit & (us_is_io ? 4'hC : 4'h3);

  // Downstream decode; the lowest-numbered window wins where windows overlap

  always_comb begin
    next_ds_claim = ds_valid && (ds_kind_hit != 4'h0);
    next_ds_window = `CBWD_WIN_MEM0;
    next_ds_prefetch = 1'b0;
    if (ds_kind_hit[0]) begin
      next_ds_window = `CBWD_WIN_MEM0;
      next_ds_prefetch = prefetch_ctl[`CBWD_PF0_BIT];
    end else if (ds_kind_hit[1]) begin
      next_ds_window = `CBWD_WIN_MEM1;
      next_ds_prefetch = prefetch_ctl[`CBWD_PF1_BIT];
    end else if (ds_kind_hit[2]) begin
      next_ds_window = `CBWD_WIN_IO0;
    end else if (ds_kind_hit[3]) begin
      next_ds_window = `CBWD_WIN_IO1;
    end
  end

  function automatic logic [1:0] next_claim_window(input logic claim, input logic [1:0] win);
    next_claim_window = claim ? win : `CBWD_WIN_MEM0;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ds_claim <= 1'b0;
      ds_window <= `CBWD_WIN_MEM0;
      ds_prefetch <= 1'b0;
    end else begin
      ds_claim <= next_ds_claim;
      ds_window <= next_claim_window(next_ds_claim, next_ds_window);
      ds_prefetch <= next_ds_claim && next_ds_prefetch;
    end
  end

  // Upstream: a card cycle goes to PCI only when it falls outside every window of its own space
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      us_forward <= 1'b0;
    end else begin
      us_forward <= us_valid && (us_kind_hit == 4'h0);
    end
  end

  // Checks

  sequence s_reg_write(logic [7:0] ofs);
    state == cbwd_pkg::ST_WRITE && addr_q == ofs;
  endsequence

  sequence s_mem_req;
    ds_valid && !ds_is_io;
  endsequence

  mem_limit_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg_write(`CBWD_OFS_MEM0_LIM) |=> mem_lim[0] == ($past(hwdata) & `CBWD_MEM_WMASK))
    else $error("memory limit 0 did not take written upper bits");

  mem_limit_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mem_lim[0][`CBWD_MEM_LOW_F] == 12'h000 && mem_lim[1][`CBWD_MEM_LOW_F] == 12'h000)
    else $error("memory limit low bits not zero");

  prefetch_sel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_mem_req ##0 ds_kind_hit[0]) |=> ds_claim && ds_window == `CBWD_WIN_MEM0
      && ds_prefetch == $past(prefetch_ctl[`CBWD_PF0_BIT]))
    else $error("window 0 prefetch does not follow control bit");

  prefetch_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_mem_req ##0 (ds_kind_hit[1:0] == 2'b10)) |=> ds_claim && ds_window == `CBWD_WIN_MEM1
      && ds_prefetch == $past(prefetch_ctl[`CBWD_PF1_BIT]))
    else $error("window 1 prefetch does not follow control bit");

  mem_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_mem_req ##0 (win_en[1:0] == 2'b00)) |=> !ds_claim)
    else $error("memory claim with both windows zeroed");

  io_base_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    io_base[0][`CBWD_IO_DW_F] == 2'b00 && io_base[1][`CBWD_IO_DW_F] == 2'b00)
    else $error("I/O base low bits not zero");

  io_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ds_valid && ds_is_io && win_en[3:2] == 2'b00) |=> !ds_claim)
    else $error("I/O claim with both windows zeroed");

  io_limit_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg_write(`CBWD_OFS_IO0_LIM) |=> io_lim[0][`CBWD_IO_PAGE_F] == 16'h0000
      && io_lim[0][`CBWD_IO_DW_F] == 2'b00
      && io_lim[0][`CBWD_IO_OFS_F] == $past(hwdata[`CBWD_IO_OFS_F]))
    else $error("I/O limit read-only bits took a write");

  io_last_dword_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ds_valid && ds_is_io && win_en[2] && ds_addr == win_hi[2]
      && ds_addr >= io_base[0]) |=> ds_claim && ds_window == `CBWD_WIN_IO0)
    else $error("last doubleword of I/O window 0 not claimed");

  upstream_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (us_valid && us_kind_hit != 4'h0) |=> !us_forward)
    else $error("card cycle inside a window forwarded upstream");

  irq_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    s_reg_write(`CBWD_OFS_IRQ_LINE) |=> irq_line == $past(hwdata[`CBWD_IRQ_F])
      ##1 ($past(state) == cbwd_pkg::ST_WRITE || irq_line == $past(irq_line)))
    else $error("interrupt routing register not written as a byte");

  read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite) |=> !hreadyout ##1 (hreadyout && hrdata == $past(next_rdata)))
    else $error("read answer timing wrong");

endmodule

/* File: src/cbwd_map.svh */
// Purpose: Offsets, write masks and reset values of the window decoder
// Assumes: Byte addresses on a 32-bit AHB-Lite data bus
// Notes: Definitions only
`ifndef CBWD_MAP_SVH
`define CBWD_MAP_SVH

`define CBWD_OFS_MEM0_BASE 8'h1C
`define CBWD_OFS_MEM0_LIM 8'h20
`define CBWD_OFS_MEM1_BASE 8'h24
`define CBWD_OFS_MEM1_LIM 8'h28
`define CBWD_OFS_IO0_BASE 8'h2C
`define CBWD_OFS_IO0_LIM 8'h30
`define CBWD_OFS_IO1_BASE 8'h34
`define CBWD_OFS_IO1_LIM 8'h38
`define CBWD_OFS_IRQ_LINE 8'h3C
`define CBWD_OFS_PREFETCH 8'h40
`define CBWD_OFS_STATUS 8'h44

`define CBWD_ADDR_F 7:0
`define CBWD_HTRANS_ACT 1

`define CBWD_REG_RST 32'h0000_0000
`define CBWD_IRQ_RST 8'hFF
`define CBWD_WORD_ZERO 32'h0000_0000

`define CBWD_MEM_WMASK 32'hFFFF_F000
`define CBWD_MEM_LOW_ONES 32'h0000_0FFF
`define CBWD_IO_BASE_WMASK 32'hFFFF_FFFC
`define CBWD_IO_LIM_WMASK 32'h0000_FFFC
`define CBWD_IO_LOW_ONES 2'b11
`define CBWD_IO_PAGE_F 31:16
`define CBWD_IO_OFS_F 15:2
`define CBWD_IO_DW_F 1:0
`define CBWD_MEM_LOW_F 11:0
`define CBWD_IRQ_F 7:0

`define CBWD_PF_MASK 32'h0000_0300
`define CBWD_PF0_BIT 8
`define CBWD_PF1_BIT 9

`define CBWD_WIN_MEM0 2'h0
`define CBWD_WIN_MEM1 2'h1
`define CBWD_WIN_IO0 2'h2
`define CBWD_WIN_IO1 2'h3

`endif

/* File: src/cbwd_pkg.sv */
// Purpose: Shared types of the window decoder
// Assumes: Nothing beyond the map header
// Notes: Constants live in cbwd_map.svh
package cbwd_pkg;
  typedef logic [31:0] cbwd_word_t;
  typedef enum {
    ST_IDLE,
    ST_WRITE,
    ST_READ,
    ST_READ_OUT
  } cbwd_bus_state_e;
endpackage

/* File: src/cbwd_window.sv */
// Purpose: Inclusive range compare of one address window against two addresses
// Assumes: Bounds already aligned and extended by the caller
// Notes: Shared by the downstream and upstream decode paths
`timescale 1ns/1ps
module cbwd_window (
  // Clock and reset, used by the checks only
  input wire logic hclk,
  input wire logic hresetn,
  // Window bounds
  input wire logic win_en,
  input wire cbwd_pkg::cbwd_word_t lo,
  input wire cbwd_pkg::cbwd_word_t hi,
  // Compared addresses
  input wire cbwd_pkg::cbwd_word_t addr_a,
  input wire cbwd_pkg::cbwd_word_t addr_b,
  output logic hit_a,
  output logic hit_b
);
  // Full 32-bit compare, both ends inclusive
  assign hit_a = win_en && (addr_a >= lo) && (addr_a <= hi);
  assign hit_b = win_en && (addr_b >= lo) && (addr_b <= hi);

  // Both ends of a live window must count as inside
  win_ends_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (win_en && lo <= hi && (addr_a == lo || addr_a == hi)) |-> hit_a)
    else $error("window end address not inside window");
endmodule

/* File: tb/cbwd_agent.sv */
// Purpose: PCI host and card master model that issues window decode requests
// Assumes: Each request is launched right after a rising edge of clk
// Notes: Released address lines show the inverse of the last value
`timescale 1ns/1ps
module cbwd_agent (
  // Clock
  input wire logic clk,
  // Downstream request
  output logic ds_valid,
  output logic [31:0] ds_addr,
  output logic ds_is_io,
  // Upstream request
  output logic us_valid,
  output logic [31:0] us_addr,
  output logic us_is_io
);
  initial begin
    ds_valid = 1'b0;
    ds_addr = 32'h0000_0000;
    ds_is_io = 1'b0;
    us_valid = 1'b0;
    us_addr = 32'h0000_0000;
    us_is_io = 1'b0;
  end

  // Both paths ask about one address, so one compare judges both decoders
  task automatic req(input logic [31:0] a, input logic io);
    ds_valid <= 1'b1;
    us_valid <= 1'b1;
    ds_addr <= a;
    us_addr <= a;
    ds_is_io <= io;
    us_is_io <= io;
    @(posedge clk);
    ds_valid <= 1'b0;
    us_valid <= 1'b0;
    ds_addr <= ~a;
    us_addr <= ~a;
    ds_is_io <= ~io;
    us_is_io <= ~io;
  endtask
endmodule

/* File: tb/cbwd_top_tb_top.sv */
// Purpose: Self-checking bench of the window registers and decode paths
// Assumes: One slave, so hready is its own hreadyout
// Notes: Decode answers are sampled at the edge after the one that takes them
`timescale 1ns/1ps
`include "cbwd_map.svh"
module cbwd_top_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic hreadyout, hresp, ds_valid, ds_is_io, us_valid, us_is_io;
  logic ds_claim, ds_prefetch, us_forward;
  logic [31:0] hrdata, ds_addr, us_addr, rdat;
  logic [1:0] ds_window;
  int failures = 0;
  int n_tests = 0;
  localparam logic [7:0] OFS [6] = '{`CBWD_OFS_MEM0_LIM, `CBWD_OFS_MEM1_LIM,
    `CBWD_OFS_IO0_BASE, `CBWD_OFS_IO1_LIM, `CBWD_OFS_IRQ_LINE, `CBWD_OFS_PREFETCH};
  localparam logic [31:0] MSK [6] = '{32'hFFFF_F000, 32'hFFFF_F000,
    32'hFFFF_FFFC, 32'h0000_FFFC, 32'h0000_00FF, 32'h0000_0300};

  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  cbwd_top cbwd_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ds_valid, .ds_addr, .ds_is_io,
    .ds_claim, .ds_window, .ds_prefetch, .us_valid, .us_addr, .us_is_io, .us_forward);
  cbwd_agent cbwd_agent_i (.clk(hclk), .ds_valid, .ds_addr, .ds_is_io, .us_valid,
    .us_addr, .us_is_io);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Compares %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A slave that never raises hready ends the run instead of hanging it
  task automatic wait_rdy();
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) return;
    end
    failures++;
    results();
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdat = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  // Expected bits: claim, window (2), prefetch, forward
  task automatic dec(input logic [31:0] a, input logic io, input logic [4:0] exp);
    cbwd_agent_i.req(a, io);
    @(posedge hclk);
    chk({27'h000_0000, ds_claim, ds_window, ds_prefetch, us_forward}, {27'h000_0000, exp});
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    for (int k = 0; k < 9; k++) begin
      rchk(8'h1C + 8'(4 * k), (k == 8) ? 32'h0000_00FF : 32'h0000_0000);
    end
    dec(32'h0000_0100, 1'b0, 5'h01);
    dec(32'h0000_0000, 1'b1, 5'h01);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, OFS[k], 32'hFFFF_FFFF);
      rchk(OFS[k], MSK[k]);
    end
    bus(1'b1, `CBWD_OFS_IRQ_LINE, 32'hFFFF_FFA5);
    rchk(`CBWD_OFS_IRQ_LINE, 32'h0000_00A5);
    bus(1'b1, 8'h80, 32'hFFFF_FFFF);
    rchk(8'h80, 32'h0000_0000);
    bus(1'b1, `CBWD_OFS_MEM0_BASE, 32'h1000_0000);
    bus(1'b1, `CBWD_OFS_MEM0_LIM, 32'h1000_1234);
    rchk(`CBWD_OFS_MEM0_LIM, 32'h1000_1000);
    bus(1'b1, `CBWD_OFS_MEM1_BASE, 32'h2000_0000);
    bus(1'b1, `CBWD_OFS_MEM1_LIM, 32'h2000_0000);
    bus(1'b1, `CBWD_OFS_IO0_BASE, 32'h0003_1001);
    rchk(`CBWD_OFS_IO0_BASE, 32'h0003_1000);
    bus(1'b1, `CBWD_OFS_IO0_LIM, 32'hFFFF_2001);
    rchk(`CBWD_OFS_IO0_LIM, 32'h0000_2000);
    bus(1'b1, `CBWD_OFS_IO1_LIM, 32'h0000_0010);
    bus(1'b1, `CBWD_OFS_PREFETCH, 32'h0000_0100);
    rchk(`CBWD_OFS_STATUS, 32'h0000_000F);
    dec(32'h0FFF_FFFF, 1'b0, 5'h01);
    dec(32'h1000_0000, 1'b0, 5'h12);
    dec(32'h1000_1FFF, 1'b0, 5'h12);
    dec(32'h1000_2000, 1'b0, 5'h01);
    dec(32'h2000_0FFF, 1'b0, 5'h14);
    dec(32'h1000_0000, 1'b1, 5'h01);
    bus(1'b1, `CBWD_OFS_PREFETCH, 32'h0000_0200);
    dec(32'h1000_0000, 1'b0, 5'h10);
    dec(32'h2000_0000, 1'b0, 5'h16);
    dec(32'h0003_2003, 1'b1, 5'h18);
    dec(32'h0003_1000, 1'b1, 5'h18);
    dec(32'h0003_0FFF, 1'b1, 5'h01);
    dec(32'h0003_2004, 1'b1, 5'h01);
    dec(32'h0002_2000, 1'b1, 5'h01);
    dec(32'h0004_2000, 1'b1, 5'h01);
    dec(32'h0000_0013, 1'b1, 5'h1C);
    dec(32'h0003_1000, 1'b0, 5'h01);
    bus(1'b1, `CBWD_OFS_IO1_LIM, 32'h0000_0000);
    dec(32'h0000_0000, 1'b1, 5'h01);
    bus(1'b1, `CBWD_OFS_MEM1_BASE, 32'h0000_0000);
    bus(1'b1, `CBWD_OFS_MEM1_LIM, 32'h0000_0000);
    dec(32'h0000_0000, 1'b0, 5'h01);
    rchk(`CBWD_OFS_STATUS, 32'h0000_0005);
    results();
  end
endmodule
